/* src/eds_page_translation.sv */
// Extended data space page translation for core data accesses
`timescale 1ns/1ns
module eds_page_translation (
  input wire logic sys_clk,
  input wire logic rst,
  input wire eds_pkg::eds_req_s req,
  input wire logic rd_page_we,
  input wire logic wr_page_we,
  input wire logic [eds_pkg::PAGE_W-1:0] page_wdata,
  output eds_pkg::eds_acc_s acc,
  output logic addr_trap,
  output logic [eds_pkg::PAGE_W-1:0] data_read_page,
  output logic [eds_pkg::PAGE_W-1:0] data_write_page
);
  logic [eds_pkg::PAGE_W-1:0] rd_page_r, rd_page_nxt;
  logic [eds_pkg::PAGE_W-1:0] wr_page_r, wr_page_nxt;
  eds_pkg::eds_acc_s acc_r, acc_nxt;
  logic trap_r, trap_nxt;
  logic [eds_pkg::PAGE_W-1:0] sel_page;
  logic upper;

  // Top page bit falls off the 24-bit extended address
  function automatic logic [eds_pkg::XA_W-1:0] map_upper(
    input logic [eds_pkg::PAGE_W-1:0] page,
    input logic [eds_pkg::EA_W-1:0] ea);
    return {page[eds_pkg::PG_LSB_W-1:0], ea[eds_pkg::WIN_W-1:0]};
  endfunction

  function automatic logic page_ok(
    input logic [eds_pkg::PAGE_W-1:0] page);
    return page != eds_pkg::PAGE_ZERO;
  endfunction

  // Page registers; a zero write is dropped, but page 0x200 still maps the window onto page 0
  always_comb begin
    rd_page_nxt = rd_page_r;
    wr_page_nxt = wr_page_r;
    if (rd_page_we && page_ok(page_wdata)) begin
      rd_page_nxt = page_wdata;
    end
    if (wr_page_we && page_ok(page_wdata)) begin
      wr_page_nxt = page_wdata;
    end
  end

  // Translation; result is registered so address and trap share one cycle
  always_comb begin
    upper = req.ea[eds_pkg::EA_TOP];
    sel_page = req.write ? wr_page_r : rd_page_r;
    acc_nxt = '0;
    trap_nxt = 1'b0;
    if (req.valid) begin
      if (!upper) begin
        // Lower half passes through as page 0, no page register involved
        acc_nxt.valid = 1'b1;
        acc_nxt.write = req.write;
        acc_nxt.xaddr = {eds_pkg::XA_HI_ZERO, req.ea};
      end else if (!page_ok(sel_page)) begin
        trap_nxt = 1'b1;
      end else begin
        acc_nxt.valid = 1'b1;
        acc_nxt.write = req.write;
        acc_nxt.xaddr = map_upper(sel_page, req.ea);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_page_r <= eds_pkg::PAGE_RESET;
      wr_page_r <= eds_pkg::PAGE_RESET;
      acc_r <= '0;
      trap_r <= 1'b0;
    end else begin
      rd_page_r <= rd_page_nxt;
      wr_page_r <= wr_page_nxt;
      acc_r <= acc_nxt;
      trap_r <= trap_nxt;
    end
  end

  assign acc = acc_r;
  assign addr_trap = trap_r;
  assign data_read_page = rd_page_r;
  assign data_write_page = wr_page_r;

  // Checks
  logic [eds_pkg::PAGE_W-1:0] page_used;
  assign page_used = req.write ? wr_page_r : rd_page_r;

  low_direct_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && !req.ea[eds_pkg::EA_TOP] |=>
      acc.valid && acc.xaddr == {eds_pkg::XA_HI_ZERO, $past(req.ea)} &&
      !addr_trap)
    else $error("Low range access not passed directly");
  low_range_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.ea <= eds_pkg::BASE_LAST |=>
      acc.xaddr[eds_pkg::XA_W-1:eds_pkg::EA_W] == eds_pkg::XA_HI_ZERO)
    else $error("Low range left page 0");
  zero_page_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.ea[eds_pkg::EA_TOP] |=>
      !(acc.valid && acc.xaddr[eds_pkg::XA_W-1:eds_pkg::WIN_W] == '0))
    else $error("Page 0 reached through window");
  never_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_page_r != eds_pkg::PAGE_ZERO && wr_page_r != eds_pkg::PAGE_ZERO)
    else $error("Page register holds zero");
  reset_val_a: assert property (@(posedge sys_clk)
    $fell(rst) |-> rd_page_r == eds_pkg::PAGE_RESET &&
      wr_page_r == eds_pkg::PAGE_RESET)
    else $error("Page registers not 0x001 after reset");
  zero_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_page_we && page_wdata == eds_pkg::PAGE_ZERO |=> $stable(rd_page_r))
    else $error("Zero write changed read page");
  trap_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    addr_trap |-> !acc.valid)
    else $error("Trap with access not suppressed");
  upper_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.ea[eds_pkg::EA_TOP] && page_used != eds_pkg::PAGE_ZERO
    |=> acc.valid && acc.xaddr == map_upper($past(page_used), $past(req.ea)))
    else $error("Upper window mapped wrongly");
  page_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.write && req.ea[eds_pkg::EA_TOP] |=>
      acc.write || addr_trap)
    else $error("Write lost its direction");

  low_cov_c: cover property (@(posedge sys_clk) disable iff (rst)
    req.valid && !req.ea[eds_pkg::EA_TOP]);
  up_rd_c: cover property (@(posedge sys_clk) disable iff (rst)
    req.valid && !req.write && req.ea[eds_pkg::EA_TOP]);
  up_wr_c: cover property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.write && req.ea[eds_pkg::EA_TOP] &&
    wr_page_r != eds_pkg::PAGE_RESET);
  zero_wr_c: cover property (@(posedge sys_clk) disable iff (rst)
    wr_page_we && page_wdata == eds_pkg::PAGE_ZERO);
  same_cyc_c: cover property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.ea[eds_pkg::EA_TOP] && rd_page_we);

  // Trap guard stays in even though page 0 cannot be loaded
  trap_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.ea[eds_pkg::EA_TOP] && !page_ok(page_used) |=>
      addr_trap && !acc.valid)
    else $error("Zero page access not trapped");

  trap_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
    addr_trap |-> $past(req.valid) && $past(req.ea[eds_pkg::EA_TOP]))
    else $error("Trap without window access");

  trap_once_a: assert property (@(posedge sys_clk) disable iff (rst)
    addr_trap && !$past(req.valid) |-> 1'b0)
    else $error("Trap held beyond one cycle");

  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    !req.valid |=> !acc.valid && !addr_trap)
    else $error("Output without request");

  rd_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_page_we && page_ok(page_wdata) |=> rd_page_r == $past(page_wdata))
    else $error("Read page not loaded");

  wr_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_page_we && page_ok(page_wdata) |=> wr_page_r == $past(page_wdata))
    else $error("Write page not loaded");

  wr_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_page_we && page_wdata == eds_pkg::PAGE_ZERO |=> $stable(wr_page_r))
    else $error("Zero write changed write page");

  rd_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && !req.write && req.ea[eds_pkg::EA_TOP] |=>
      acc.xaddr == map_upper($past(rd_page_r), $past(req.ea)))
    else $error("Read used wrong page");

  wr_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.write && req.ea[eds_pkg::EA_TOP] |=>
      acc.xaddr == map_upper($past(wr_page_r), $past(req.ea)))
    else $error("Write used wrong page");

  page_two_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && req.ea[eds_pkg::EA_TOP] &&
    page_used == eds_pkg::PAGE_TWO |=>
      acc.xaddr[eds_pkg::XA_W-1:eds_pkg::WIN_W] ==
      eds_pkg::PAGE_TWO_BASE[eds_pkg::XA_W-1:eds_pkg::WIN_W])
    else $error("Page 2 mapped wrongly");

  rd_dir_a: assert property (@(posedge sys_clk) disable iff (rst)
    req.valid && !req.write |=> !acc.write)
    else $error("Read turned into write");
endmodule

/* src/eds_pkg.sv */
// Package for the extended data space page translation block
package eds_pkg;
  localparam int EA_W = 16;
  localparam int PAGE_W = 10;
  localparam int XA_W = 24;
  localparam int WIN_W = 15;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 10'h001;
  localparam logic [PAGE_W-1:0] PAGE_ZERO = 10'h000;
  localparam int EA_TOP = 15;
  localparam logic [EA_W-1:0] BASE_LAST = 16'h2FFF;
  localparam logic [PAGE_W-1:0] HI_PAGE_ZERO = 10'h000;
  localparam int PG_LSB_W = XA_W - WIN_W;
  localparam logic [XA_W-EA_W-1:0] XA_HI_ZERO = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_TWO = 10'h002;
  localparam logic [XA_W-1:0] PAGE_TWO_BASE = 24'h010000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [EA_W-1:0] ea;
  } eds_req_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [XA_W-1:0] xaddr;
  } eds_acc_s;
endpackage

/* testbench/eds_core_model.sv */
// Core model issuing data space accesses
`timescale 1ns/1ns
module eds_core_model (
  input wire logic sys_clk,
  output eds_pkg::eds_req_s req
);
  initial req = '0;
  // One-cycle request, launched and withdrawn at falling edges
  task automatic access(input logic w, input logic [15:0] ea);
    @(negedge sys_clk);
    req = '{valid: 1'b1, write: w, ea: ea};
    @(negedge sys_clk);
    req = '0;
  endtask
endmodule

/* testbench/eds_page_translation_tb.sv */
// Self-checking bench for the page translation block
`timescale 1ns/1ns
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin \
  $display("ERROR %s exp %h got %h", n, e, s); error_cnt++; end end
module eds_page_translation_tb;
  logic sys_clk = 0, rst = 1, rd_page_we = 0, wr_page_we = 0, addr_trap;
  logic [9:0] page_wdata = '0, rp = 10'h001, wp = 10'h001;
  logic [9:0] data_read_page, data_write_page;
  logic [31:0] seed = 32'hC19B;
  int error_cnt = 0, samples_checked = 0;
  eds_pkg::eds_req_s req;
  eds_pkg::eds_acc_s acc, e, g, exp_q[$];
  eds_core_model u_eds_core_model (.sys_clk(sys_clk), .req(req));
  eds_page_translation u_eds_page_translation (.sys_clk(sys_clk),
    .rst(rst), .req(req), .rd_page_we(rd_page_we),
    .wr_page_we(wr_page_we), .page_wdata(page_wdata), .acc(acc),
    .addr_trap(addr_trap), .data_read_page(data_read_page),
    .data_write_page(data_write_page));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic pg(input logic r, input logic w, input logic [9:0] d);
    @(negedge sys_clk);
    {rd_page_we, wr_page_we, page_wdata} = {r, w, d};
    @(negedge sys_clk);
    {rd_page_we, wr_page_we} = 2'b00;
    if (r && d != 0) rp = d;
    if (w && d != 0) wp = d;
    `CHK("rd_page", rp, data_read_page)
    `CHK("wr_page", wp, data_write_page)
  endtask
  // Page is sampled before any same-cycle page write lands
  task automatic go(input logic w, input logic [15:0] ea);
    logic [9:0] p;
    p = w ? wp : rp;
    e = '{valid: 1'b1, write: w, xaddr: 24'h0};
    e.xaddr = ea[15] ? {p[8:0], ea[14:0]} : {8'h00, ea};
    exp_q.push_back(e);
    u_eds_core_model.access(w, ea);
  endtask
  task automatic rs;
    @(negedge sys_clk) rst = 1;
    repeat (2) @(negedge sys_clk);
    rst = 0;
    rp = 10'h001;
    wp = 10'h001;
    `CHK("rd_rst", rp, data_read_page)
    `CHK("wr_rst", wp, data_write_page)
  endtask
  always @(negedge sys_clk) if (!rst) begin
    `CHK("trap", 1'b0, addr_trap)
    if (acc.valid === 1'b1) begin
      g = '0;
      if (exp_q.size() > 0) g = exp_q.pop_front();
      `CHK("acc", g, acc)
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rs;
    go(0, 16'h2FFF);
    go(1, 16'h0000);
    go(0, 16'h8004);
    go(1, 16'hFFFF);
    pg(1, 0, 10'h002);
    pg(1, 1, 10'h000);
    fork pg(1, 0, 10'h3FF); go(0, 16'h8000); join
    for (int i = 0; i < 300; i++) begin
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      if (seed[3:0] == 0) pg(seed[4], seed[5], seed[25:16]);
      else go(seed[6], seed[31:16]);
    end
    repeat (3) @(negedge sys_clk);
    `CHK("pending", 0, exp_q.size())
    rs;
    go(1, 16'h8001);
    repeat (3) @(negedge sys_clk);
    complete_run;
  end
  // Hang guard: a run this long counts as a mismatch
  initial begin
    #200000;
    error_cnt++;
    complete_run;
  end
  task automatic complete_run;
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
endmodule
